// ===== src/tqs_defines.svh
// Register map, field positions and reset values of the torque-off status block.
// Assumes a 32-bit register port with byte addresses.
`ifndef TQS_DEFINES_SVH
`define TQS_DEFINES_SVH

`define TQS_ADDR_W 8
`define TQS_DATA_W 32

`define TQS_OFF_STATE 8'h00
`define TQS_OFF_CTRL 8'h04
`define TQS_OFF_IRQ_STATUS 8'h08
`define TQS_OFF_IRQ_MASK 8'h0C

`define TQS_STATE_ACTIVE 0
`define TQS_STATE_CHAN_A 1
`define TQS_STATE_CHAN_B 2
`define TQS_STATE_WARN 3
`define TQS_STATE_FAULT 4

`define TQS_CTRL_REPORT 0
`define TQS_CTRL_FAULT_CLR 1

`define TQS_EVT_W 4
`define TQS_EVT_ENTER 0
`define TQS_EVT_EXIT 1
`define TQS_EVT_FAULT 2
`define TQS_EVT_MISMATCH 3

`define TQS_REPORT_RST 1'h1
`define TQS_MASK_RST 4'h0
`define TQS_SYNC_RST 3'h0

`endif

// ===== src/tqs_pkg.sv
// Types of the torque-off status block.
// Assumes tqs_defines.svh for widths.
`include "tqs_defines.svh"

package tqs_pkg;

	typedef struct packed {
		logic [`TQS_ADDR_W-1:0] addr;
		logic [`TQS_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} tqs_bus_req_t;

	typedef struct packed {
		logic [2:0] a_sync;
		logic [2:0] b_sync;
		logic chan_a;
		logic chan_b;
		logic active;
		logic report;
		logic warn;
		logic fault;
		logic [`TQS_EVT_W-1:0] irq_status;
		logic [`TQS_EVT_W-1:0] irq_mask;
		logic irq;
		logic [`TQS_DATA_W-1:0] rdata;
	} tqs_state_t;

endpackage

// ===== src/tqs_status.sv
// Torque-off status of one drive axis: pin filtering, warning/fault, registers, interrupt.
// Assumes channel pins are asynchronous, axis_enable and the bus are on sys_clk.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "tqs_defines.svh"

// Overview of operation
// - Status reads 1 while torque off active
// - Status reads 0 while both inputs 24V
// - Fault on activation while enabled, if reporting
// - Warning follows active state while reporting
// - Reporting off: no warning, no fault
// - Reporting switch resets to 1
// - Channel state 1 at 24V, else 0
module tqs_status (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Torque-off input pins, high at 24V
	input wire logic chan_a_pin,
	input wire logic chan_b_pin,
	// Axis enable from drive logic
	input wire logic axis_enable,
	// Register port
	input wire tqs_pkg::tqs_bus_req_t bus_req,
	output logic [`TQS_DATA_W-1:0] rd_data,
	// Status outputs
	output logic axis_torque_off_state,
	output logic torque_off_channel_a_state,
	output logic torque_off_channel_b_state,
	output logic torque_off_warning,
	output logic torque_off_fault,
	output logic irq
);
	import tqs_pkg::*;

	tqs_state_t st_q;
	tqs_state_t st_d;

	// Filtered level: accept a new value only once stages two and three agree
	function automatic logic filt(input logic [2:0] sync, input logic cur);
		filt = (sync[1] == sync[2]) ? sync[2] : cur;
	endfunction

	function automatic logic hit(input tqs_bus_req_t r, input logic [`TQS_ADDR_W-1:0] off);
		hit = (r.addr == off);
	endfunction

	logic enter;
	logic leave;
	logic fault_set;
	logic fault_clr;
	logic mismatch;
	logic [`TQS_EVT_W-1:0] events;
	logic [`TQS_DATA_W-1:0] state_word;

	always_comb begin
		st_d = st_q;
		// Stage one is read only by stage two
		st_d.a_sync = {st_q.a_sync[1:0], chan_a_pin};
		st_d.b_sync = {st_q.b_sync[1:0], chan_b_pin};
		st_d.chan_a = filt(st_q.a_sync, st_q.chan_a);
		st_d.chan_b = filt(st_q.b_sync, st_q.chan_b);
		// Either channel at 0V removes torque; failing safe on one channel
		st_d.active = ~(st_d.chan_a & st_d.chan_b);

		enter = st_d.active & ~st_q.active;
		leave = ~st_d.active & st_q.active;
		mismatch = (st_d.chan_a != st_d.chan_b) & (st_q.chan_a == st_q.chan_b);

		if (bus_req.wr && hit(bus_req, `TQS_OFF_CTRL)) begin
			st_d.report = bus_req.wdata[`TQS_CTRL_REPORT];
		end
		if (bus_req.wr && hit(bus_req, `TQS_OFF_IRQ_MASK)) begin
			st_d.irq_mask = bus_req.wdata[`TQS_EVT_W-1:0];
		end
		fault_clr = bus_req.wr && hit(bus_req, `TQS_OFF_CTRL)
			&& bus_req.wdata[`TQS_CTRL_FAULT_CLR];

		fault_set = enter & axis_enable & st_d.report;
		// Set beats clear; switching reporting off drops the fault
		st_d.fault = st_d.report & (fault_set | (st_q.fault & ~fault_clr));
		st_d.warn = st_d.report & st_d.active;

		events = '0;
		events[`TQS_EVT_ENTER] = enter;
		events[`TQS_EVT_EXIT] = leave;
		events[`TQS_EVT_FAULT] = fault_set;
		events[`TQS_EVT_MISMATCH] = mismatch;
		// Read clears, but an event in the same cycle survives
		if (bus_req.rd && hit(bus_req, `TQS_OFF_IRQ_STATUS)) begin
			st_d.irq_status = events;
		end else begin
			st_d.irq_status = st_q.irq_status | events;
		end
		st_d.irq = |(st_d.irq_status & st_d.irq_mask);

		state_word = '0;
		state_word[`TQS_STATE_ACTIVE] = st_q.active;
		state_word[`TQS_STATE_CHAN_A] = st_q.chan_a;
		state_word[`TQS_STATE_CHAN_B] = st_q.chan_b;
		state_word[`TQS_STATE_WARN] = st_q.warn;
		state_word[`TQS_STATE_FAULT] = st_q.fault;

		st_d.rdata = '0;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				`TQS_OFF_STATE: st_d.rdata = state_word;
				`TQS_OFF_CTRL: st_d.rdata[`TQS_CTRL_REPORT] = st_q.report;
				`TQS_OFF_IRQ_STATUS: st_d.rdata[`TQS_EVT_W-1:0] = st_q.irq_status;
				`TQS_OFF_IRQ_MASK: st_d.rdata[`TQS_EVT_W-1:0] = st_q.irq_mask;
				default: st_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			// Channels start at 0V so the axis starts in the safe state
			st_q.a_sync <= `TQS_SYNC_RST;
			st_q.b_sync <= `TQS_SYNC_RST;
			st_q.chan_a <= 1'h0;
			st_q.chan_b <= 1'h0;
			st_q.active <= 1'h1;
			st_q.report <= `TQS_REPORT_RST;
			st_q.warn <= 1'h0;
			st_q.fault <= 1'h0;
			st_q.irq_status <= '0;
			st_q.irq_mask <= `TQS_MASK_RST;
			st_q.irq <= 1'h0;
			st_q.rdata <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rd_data = st_q.rdata;
	assign axis_torque_off_state = st_q.active;
	assign torque_off_channel_a_state = st_q.chan_a;
	assign torque_off_channel_b_state = st_q.chan_b;
	assign torque_off_warning = st_q.warn;
	assign torque_off_fault = st_q.fault;
	assign irq = st_q.irq;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence a_low_s;
		!chan_a_pin [*4];
	endsequence

	sequence both_high_s;
		(chan_a_pin && chan_b_pin) [*4];
	endsequence

	sequence armed_entry_s;
		$rose(axis_torque_off_state) && $past(axis_enable) && torque_off_warning;
	endsequence

	active_on_zero_a: assert property (a_low_s |=> axis_torque_off_state)
		else $error("status not active after channel a held at 0V");

	inactive_on_24v_a: assert property (both_high_s |=> !axis_torque_off_state)
		else $error("status still active with both channels at 24V");

	fault_on_entry_a: assert property (armed_entry_s |-> torque_off_fault)
		else $error("fault missing on activation while enabled");

	fault_cause_a: assert property ($rose(torque_off_fault)
		|-> $rose(axis_torque_off_state) && $past(axis_enable))
		else $error("fault raised without activation while enabled");

	// The warning flop is held at 0 in reset, so skip the first edge after release
	warn_follows_a: assert property (!$past(reset) |-> torque_off_warning
		== (axis_torque_off_state && $past(st_d.report)))
		else $error("warning does not follow active state");

	report_off_quiet_a: assert property (!st_q.report |-> !torque_off_warning
		&& !torque_off_fault)
		else $error("warning or fault with reporting off");

	report_reset_a: assert property ($fell(reset) |-> st_q.report)
		else $error("reporting switch not 1 after reset");

	chan_high_a: assert property (chan_b_pin [*4] |=> torque_off_channel_b_state)
		else $error("channel b not 1 at 24V");

	chan_low_a: assert property (!chan_b_pin [*4] |=> !torque_off_channel_b_state)
		else $error("channel b not 0 at 0V");

	chan_settled_a: assert property ($changed(torque_off_channel_a_state)
		|-> torque_off_channel_a_state == $past(chan_a_pin, 3))
		else $error("channel a changed without settled input");

	irq_level_a: assert property (##1 irq == |($past(st_d.irq_status & st_d.irq_mask)))
		else $error("interrupt does not follow masked status");

	read_clears_a: assert property (bus_req.rd && bus_req.addr == `TQS_OFF_IRQ_STATUS
		&& events == '0 |=> st_q.irq_status == '0)
		else $error("status read did not clear events");

endmodule

// ===== bench/tqs_safety_dev.sv
// Model of the external safety device driving both torque-off channels.
// Assumes the bench sets the wanted levels; 1 means 24V present.
`timescale 1ns/1ps
module tqs_safety_dev (
	// Clock
	input wire logic sys_clk,
	// Wanted levels, b1 channel B, b0 channel A
	input wire logic [1:0] cmd,
	// Channel pins
	output logic chan_a_pin,
	output logic chan_b_pin
);
	// Contacts switch on the clock, so every level lasts whole cycles
	always_ff @(posedge sys_clk) begin
		chan_a_pin <= cmd[0];
		chan_b_pin <= cmd[1];
	end
endmodule

// ===== bench/tqs_status_test.sv
// Self-checking bench of the torque-off status block.
// Assumes the safety device model and the register map header.
`timescale 1ns/1ps
`include "tqs_defines.svh"
module tqs_status_test;
	import tqs_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic axis_enable = 1'b0;
	logic [1:0] cmd = 2'h3;
	tqs_bus_req_t req = '0;
	logic [31:0] rd_data, d, rng;
	logic chan_a_pin, chan_b_pin, act, cha, chb, warn, fault, irq;
	int n_errors = 0;
	int checks_done = 0;
	always #2.5 sys_clk = ~sys_clk;
	tqs_safety_dev tqs_safety_dev_i (.sys_clk(sys_clk), .cmd(cmd), .chan_a_pin(chan_a_pin),
		.chan_b_pin(chan_b_pin));
	tqs_status tqs_status_i (.sys_clk(sys_clk), .reset(reset), .chan_a_pin(chan_a_pin),
		.chan_b_pin(chan_b_pin), .axis_enable(axis_enable), .bus_req(req), .rd_data(rd_data),
		.axis_torque_off_state(act), .torque_off_channel_a_state(cha),
		.torque_off_channel_b_state(chb), .torque_off_warning(warn), .torque_off_fault(fault),
		.irq(irq));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// Reference: active when either channel lacks 24V
	function automatic logic [31:0] model(input int c, input int rep, input int flt);
		int a;
		a = (c != 3);
		return 32'(a + 2 * (c & 3) + 8 * (a & rep) + 16 * flt);
	endfunction
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= v;
		@(posedge sys_clk);
		req.wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge sys_clk);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge sys_clk);
		req.rd <= 1'b0;
		#1 d = rd_data;
	endtask
	task chk_state(input logic [31:0] e);
		rd(`TQS_OFF_STATE);
		chk("state", e, d);
		chk("pins", e, {27'h0, fault, warn, chb, cha, act});
	endtask
	// Pins go through a 3-stage filter, so allow six cycles
	task step(input logic [1:0] c);
		@(posedge sys_clk);
		cmd <= c;
		repeat (6) @(posedge sys_clk);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		rng = 32'hB40F;
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		step(2'h3);
		rd(`TQS_OFF_CTRL);
		chk("ctrl", 32'h1, d);
		chk_state(model(3, 1, 0));
		rd(8'h10);
		chk("unmapped", 32'h0, d);
		rd(`TQS_OFF_IRQ_STATUS);
		chk("irq status exit", 32'h2, d);
		$display("reset test done");
		axis_enable <= 1'b1;
		step(2'h2);
		chk_state(model(2, 1, 1));
		chk("irq masked", 32'h0, 32'(irq));
		wr(`TQS_OFF_IRQ_MASK, 32'h1);
		repeat (2) @(posedge sys_clk);
		#1 chk("irq", 32'h1, 32'(irq));
		rd(`TQS_OFF_IRQ_STATUS);
		chk("irq status", 32'hD, d);
		@(posedge sys_clk);
		#1 chk("irq cleared", 32'h0, 32'(irq));
		wr(`TQS_OFF_CTRL, 32'h3);
		chk_state(model(2, 1, 0));
		$display("fault test done");
		wr(`TQS_OFF_CTRL, 32'h0);
		chk_state(model(2, 0, 0));
		step(2'h3);
		step(2'h0);
		chk_state(model(0, 0, 0));
		$display("report off test done");
		axis_enable <= 1'b0;
		wr(`TQS_OFF_CTRL, 32'h1);
		for (int i = 0; i < 16; i++) begin
			rng = xs(rng);
			step(rng[1:0]);
			chk_state(model(int'(rng[1:0]), 1, 0));
		end
		$display("random test done");
		print_verdict();
	end
endmodule
